// >>> mdac_update_ctrl.sv
// Update control of a 40-channel DAC: reset sequence, park, busy/load, power-down, toggle.
`timescale 1ns/100ps
module mdac_update_ctrl import mdac_pkg::*; (
  // Clock and reset
  input  wire logic                         sys_clk,
  input  wire logic                         rstn,
  // Pins from the host and the sensor, asynchronous
  input  wire mdac_pins_t                   pinIn,
  // Register writes from the serial front end
  input  wire mdac_wr_t                     wrCmd,
  // Open-drain busy line
  output logic                              busyOut,
  output logic                              busyOe,
  // Channel state
  output logic [CH_NUM-1:0][CODE_W-1:0]     chanCode,
  output logic                              outputsParked,
  output logic                              resetActive,
  // Register readback
  output logic [7:0]                        controlRead,
  output logic [BANKS-1:0][7:0]             selectRead
);

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  mdac_pins_t syncA_reg, syncB_reg, prev_reg;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      syncA_reg <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
      syncB_reg <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
      prev_reg  <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    end else begin
      syncA_reg <= pinIn;
      syncB_reg <= syncA_reg;
      prev_reg  <= syncB_reg;
    end
  end

  logic seqStart, fallEv, parkOn;
  assign seqStart = syncB_reg.resetPin_n && !prev_reg.resetPin_n;
  assign fallEv   = prev_reg.loadStrobe_n && !syncB_reg.loadStrobe_n;
  assign parkOn   = !syncB_reg.outputPark_n;

  // ************************************************************
  // Control, select banks and reset sequence
  // ************************************************************
  logic [7:0]            ctrl_reg, ctrl_next;
  logic [BANKS-1:0][7:0] sel_reg, sel_next;
  logic [2:0]            selCnt_reg, selCnt_next;
  logic [11:0]           seqCnt_reg, seqCnt_next;
  logic                  therm_reg, therm_next;
  logic                  hold_reg, hold_next;
  logic                  seqOn_reg;
  logic                  wrOk, wrSel, doLoad;
  logic [2:0]            selBank;

  assign wrOk    = wrCmd.valid && (seqCnt_reg == 12'h000);
  assign wrSel   = wrOk && (wrCmd.kind == WR_SELECT);
  assign selBank = wrCmd.data[SEL_BANK_LSB+2:SEL_BANK_LSB];

  always_comb begin
    ctrl_next   = ctrl_reg;
    sel_next    = sel_reg;
    selCnt_next = (selCnt_reg != 3'h0) ? selCnt_reg - 3'h1 : 3'h0;
    seqCnt_next = (seqCnt_reg != 12'h000) ? seqCnt_reg - 12'h001 : 12'h000;
    hold_next   = hold_reg;
    if (wrOk && (wrCmd.kind == WR_CONTROL)) begin
      ctrl_next = wrCmd.data[7:0];
    end
    if (wrSel && (selBank < 3'(BANKS))) begin
      sel_next[selBank] = wrCmd.data[7:0];
      selCnt_next       = 3'(SEL_CYC);
    end
    // Hardware holds bit 4; software cannot write it.
    ctrl_next[CTRL_TSD_FLAG] = 1'b0;
    // Thermal latch clears only when its enable is low, so set wins otherwise.
    therm_next = ctrl_reg[CTRL_TSD_EN] && (therm_reg || syncB_reg.overTemp);
    if (doLoad) begin
      hold_next = 1'b0;
    end
    if (seqStart) begin
      seqCnt_next = 12'(RESET_CYC);
      hold_next   = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg   <= CTRL_RESET;
      sel_reg    <= '0;
      selCnt_reg <= 3'h0;
      seqCnt_reg <= 12'h000;
      therm_reg  <= 1'b0;
      hold_reg   <= 1'b1;
      seqOn_reg  <= 1'b0;
    end else begin
      ctrl_reg   <= ctrl_next;
      sel_reg    <= sel_next;
      selCnt_reg <= selCnt_next;
      seqCnt_reg <= seqCnt_next;
      therm_reg  <= therm_next;
      hold_reg   <= hold_next;
      seqOn_reg  <= (seqCnt_next != 12'h000);
    end
  end

  // ************************************************************
  // Shared calculator scheduling
  // ************************************************************
  mdac_calc_t    calc_reg, calc_next;
  logic [79:0]   pend_reg, pend_next, pendAll, wrBits;
  logic [6:0]    idx_reg, idx_next;
  logic [3:0]    cnt_reg, cnt_next;
  logic          calcDone, busyDrv_reg, busyDrv_next, busyAny, busyAnyPrev_reg;
  logic          wrCalc;

  function automatic logic [6:0] lowestSet(input logic [79:0] v);
    logic [6:0] r;
    r = 7'h00;
    for (int i = 79; i >= 0; i--) begin
      if (v[i]) begin
        r = 7'(i);
      end
    end
    return r;
  endfunction : lowestSet

  assign wrCalc   = wrOk && (wrCmd.kind inside {WR_INPUT, WR_GAIN, WR_OFFSET});
  assign calcDone = (calc_reg == CALC_STAGE) && (cnt_reg == 4'h0);

  always_comb begin
    wrBits = '0;
    if (wrCalc) begin
      // Input writes follow the A/B target bit; gain and offset refresh that same result.
      if (ctrl_reg[CTRL_AB_BIT]) begin
        wrBits[79:40] = wrCmd.chans;
      end else begin
        wrBits[39:0] = wrCmd.chans;
      end
    end
  end

  always_comb begin
    pendAll   = pend_reg | wrBits;
    pend_next = pendAll;
    calc_next = calc_reg;
    idx_next  = idx_reg;
    cnt_next  = (cnt_reg != 4'h0) ? cnt_reg - 4'h1 : 4'h0;
    case (calc_reg)
      CALC_IDLE: begin
        if (pendAll != '0) begin
          calc_next = CALC_STAGE;
          idx_next  = lowestSet(pendAll);
          cnt_next  = 4'(STAGE_CYC - 1);
        end
      end
      CALC_STAGE: begin
        if (cnt_reg == 4'h0) begin
          // A rewrite of the same channel in the last cycle of its stage keeps it pending.
          pend_next          = pend_reg;
          pend_next[idx_reg] = 1'b0;
          pend_next          = pend_next | wrBits;
          if (pend_next != '0) begin
            idx_next = lowestSet(pend_next);
            cnt_next = 4'(STAGE_CYC - 1);
          end else begin
            calc_next = CALC_FINAL;
            cnt_next  = 4'(STAGE_CYC + FINAL_CYC - 1);
          end
        end
      end
      CALC_FINAL: begin
        if (pendAll != '0) begin
          calc_next = CALC_STAGE;
          idx_next  = lowestSet(pendAll);
          cnt_next  = 4'(STAGE_CYC - 1);
        end else if (cnt_reg == 4'h0) begin
          calc_next = CALC_IDLE;
        end
      end
      default: begin
        calc_next = CALC_IDLE;
      end
    endcase
    if (seqStart) begin
      calc_next = CALC_IDLE;
      pend_next = '0;
    end
    busyDrv_next = (calc_next != CALC_IDLE) || (selCnt_next != 3'h0)
                   || (seqCnt_next != 12'h000);
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      calc_reg        <= CALC_IDLE;
      pend_reg        <= '0;
      idx_reg         <= 7'h00;
      cnt_reg         <= 4'h0;
      busyDrv_reg     <= 1'b0;
      busyAnyPrev_reg <= 1'b0;
    end else begin
      calc_reg        <= calc_next;
      pend_reg        <= pend_next;
      idx_reg         <= idx_next;
      cnt_reg         <= cnt_next;
      busyDrv_reg     <= busyDrv_next;
      busyAnyPrev_reg <= busyAny;
    end
  end

  // A low from any tied device counts; our own drive is seen before the line echo.
  assign busyAny = busyDrv_reg || !syncB_reg.busyLine;

  // ************************************************************
  // Load strobe handling
  // ************************************************************
  logic loadPend_reg, loadPend_next, busyRise;

  assign busyRise = busyAnyPrev_reg && !busyAny;
  assign doLoad   = !parkOn && !busyAny
                    && (loadPend_reg || fallEv || (busyRise && !syncB_reg.loadStrobe_n));

  always_comb begin
    loadPend_next = loadPend_reg;
    if (parkOn || doLoad) begin
      loadPend_next = 1'b0;
    end else if (fallEv) begin
      loadPend_next = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      loadPend_reg <= 1'b0;
    end else begin
      loadPend_reg <= loadPend_next;
    end
  end

  // ************************************************************
  // Result arithmetic for the channel in its stage
  // ************************************************************
  mdac_chan_t  ch_reg [CH_NUM];
  mdac_chan_t  ch_next[CH_NUM];
  mdac_chan_t  cur;
  logic        curB;
  logic [28:0] prod;
  logic signed [17:0] sum;
  logic [13:0] calcRes;

  assign curB = (idx_reg >= 7'(CH_NUM));
  assign cur  = ch_reg[curB ? 6'(idx_reg - 7'(CH_NUM)) : 6'(idx_reg)];

  always_comb begin
    prod = 29'((curB ? cur.inB : cur.inA) * ({1'b0, cur.gain} + 15'h0001));
    sum  = $signed({3'b000, prod[28:14]}) + $signed({4'h0, cur.offs}) - CODE_MID;
    if (sum < 18'sh00000) begin
      calcRes = 14'h0000;
    end else if (sum > CODE_MAX) begin
      calcRes = 14'h3fff;
    end else begin
      calcRes = sum[13:0];
    end
  end

  // ************************************************************
  // Per-channel registers
  // ************************************************************
  for (genvar c = 0; c < CH_NUM; c++) begin : gChan
    logic selB, selNow;
    assign selNow = sel_reg[c / 8][c % 8];
    assign selB   = sel_next[c / 8][c % 8];

    always_comb begin
      ch_next[c] = ch_reg[c];
      if (wrOk && wrCmd.chans[c]) begin
        case (wrCmd.kind)
          WR_INPUT: begin
            if (ctrl_reg[CTRL_AB_BIT]) begin
              ch_next[c].inB = wrCmd.data;
            end else begin
              ch_next[c].inA = wrCmd.data;
            end
          end
          WR_GAIN:   ch_next[c].gain = wrCmd.data;
          WR_OFFSET: ch_next[c].offs = wrCmd.data;
          default:   ch_next[c].gain = ch_reg[c].gain;
        endcase
      end
      // Clear from the load first, so a result written this cycle stays dirty.
      if (doLoad && (selNow ? ch_reg[c].dirtyB : ch_reg[c].dirtyA)) begin
        ch_next[c].dac = selNow ? ch_reg[c].resB : ch_reg[c].resA;
        if (selNow) begin
          ch_next[c].dirtyB = 1'b0;
        end else begin
          ch_next[c].dirtyA = 1'b0;
        end
      end
      if (calcDone && (idx_reg == 7'(c))) begin
        ch_next[c].resA   = calcRes;
        ch_next[c].dirtyA = 1'b1;
      end
      if (calcDone && (idx_reg == 7'(c + CH_NUM))) begin
        ch_next[c].resB   = calcRes;
        ch_next[c].dirtyB = 1'b1;
      end
      // A toggle write arms the newly chosen level for the next load.
      if (wrSel && (selBank == 3'(c / 8))) begin
        if (selB) begin
          ch_next[c].dirtyB = 1'b1;
        end else begin
          ch_next[c].dirtyA = 1'b1;
        end
      end
      if (seqStart) begin
        ch_next[c] = '{INPUT_DEF, INPUT_DEF, GAIN_DEF, OFFSET_DEF,
                       INPUT_DEF, INPUT_DEF, INPUT_DEF, 1'b0, 1'b0};
      end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
        ch_reg[c] <= '{INPUT_DEF, INPUT_DEF, GAIN_DEF, OFFSET_DEF,
                       INPUT_DEF, INPUT_DEF, INPUT_DEF, 1'b0, 1'b0};
      end else begin
        ch_reg[c] <= ch_next[c];
      end
    end

    assign chanCode[c] = ch_reg[c].dac;
  end

  // ************************************************************
  // Output parking
  // ************************************************************
  logic park_reg, park_next;

  // Parking only switches the buffers, so stored codes survive it.
  assign park_next = parkOn || ctrl_reg[CTRL_PD_BIT] || therm_reg || hold_reg;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      park_reg <= 1'b1;
    end else begin
      park_reg <= park_next;
    end
  end

  logic zero_reg;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      zero_reg <= 1'b0;
    end else begin
      zero_reg <= 1'b0;
    end
  end

  assign busyOut       = zero_reg;
  assign busyOe        = busyDrv_reg;
  assign outputsParked = park_reg;
  assign resetActive   = seqOn_reg;
  assign selectRead    = sel_reg;
  assign controlRead   = {ctrl_reg[7:5], therm_reg, ctrl_reg[3:0]};

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  AST_SEQ_RESTORE: assert property (seqStart |=> resetActive && ch_reg[0].inA == INPUT_DEF
    && ch_reg[CH_NUM-1].gain == GAIN_DEF && ch_reg[0].dac == INPUT_DEF)
    else $error("reset sequence did not restore defaults");
  AST_FALL_IGNORED: assert property (!syncB_reg.resetPin_n && !resetActive |=> !resetActive)
    else $error("reset pin low started a sequence");
  AST_PARK_GROUND: assert property (parkOn |=> outputsParked)
    else $error("outputs not parked while park input low");
  AST_PARK_NO_LOAD: assert property (parkOn |-> !doLoad)
    else $error("load taken while parked");
  AST_PARK_KEEPS: assert property (parkOn && !seqStart |=> $stable(chanCode))
    else $error("channel codes changed while parked");
  AST_WRITE_BUSY: assert property (wrCalc && !seqStart |=> busyOe)
    else $error("busy not driven after channel write");
  AST_NO_UPD_BUSY: assert property (busyAny && !seqStart |=> $stable(chanCode))
    else $error("output updated while busy");
  AST_STORE_LOAD: assert property (fallEv && busyAny && !parkOn |=> loadPend_reg)
    else $error("load during busy not stored");
  AST_SEL_BUSY: assert property (wrSel && selBank < 3'(BANKS) && !seqStart |=> busyOe [*5])
    else $error("select write busy too short");
  AST_BUSY_LEN: assert property (wrCalc && calc_reg == CALC_IDLE && !seqStart
    |=> busyOe [*8] ##7 busyOe)
    else $error("busy shorter than one channel time");
  AST_THERM_FLAG: assert property (ctrl_reg[CTRL_TSD_EN] && syncB_reg.overTemp
    |=> controlRead[CTRL_TSD_FLAG] ##1 outputsParked)
    else $error("thermal flag not set");
  AST_THERM_LATCH: assert property (therm_reg && ctrl_reg[CTRL_TSD_EN] |=> therm_reg)
    else $error("thermal shutdown released while enabled");
  AST_CLEAN_HOLD: assert property (doLoad && !sel_reg[0][0] && !ch_reg[0].dirtyA
    |=> $stable(chanCode[0]))
    else $error("unwritten channel updated on load");

  COV_STORED_LOAD: cover property (fallEv && busyAny ##[1:40] doLoad);
  COV_HELD_LOAD: cover property (busyRise && !syncB_reg.loadStrobe_n);
  COV_THERMAL: cover property ($rose(therm_reg));
  COV_PARK_RELEASE: cover property ($fell(outputsParked));

endmodule : mdac_update_ctrl

// >>> mdac_pkg.sv
// Shared constants, types and field layout of the DAC update control block.
// Functional notes
// - Reset pin rising edge restores channel registers.
// - Reset pin falling edge does nothing.
// - After reset, outputs parked until write plus load; code unparks on any load, even with no write.
// - Park input grounds outputs, ignores load strobes.
// - Park release restores outputs; registers unchanged.
// - Channel data writes drive busy low during calculation.
// - Writes accepted while busy; no output update; code ignores writes while the reset sequence drives busy.
// - Busy is open-drain; foreign low counts as busy.
// - Load falling during busy is stored, applied later.
// - Load held low updates whenever busy rises.
// - Select register write drives busy low 500 ns.
// - Busy time is (channels+1)*600 ns plus 300 ns.
// - One shared calculator handles channels sequentially.
// - Load copies only results written since last load; code also copies the level newly chosen by a select write, written or not.
// - Control bit 0 powers down, keeps registers.
// - Enabled over-temperature forces power-down.
// - Thermal shutdown sets control bit 4.
// - Thermal shutdown latched until enable bit cleared.
// - Five select banks pick A or B per channel.
// - Result is input*(gain+1)/2^14 + offset - 2^13.
// - Input registers default to 5461.
package mdac_pkg;
  localparam int CH_NUM       = 40;
  localparam int CODE_W       = 14;
  localparam int BANKS        = 5;
  localparam int CLK_NS       = 100;
  localparam int STAGE_NS     = 600;
  localparam int FINAL_NS     = 300;
  localparam int SEL_BUSY_NS  = 500;
  localparam int RESET_SEQ_US = 300;
  localparam int STAGE_CYC    = (STAGE_NS + CLK_NS - 1) / CLK_NS;
  localparam int FINAL_CYC    = (FINAL_NS + CLK_NS - 1) / CLK_NS;
  localparam int SEL_CYC      = (SEL_BUSY_NS + CLK_NS - 1) / CLK_NS;
  localparam int RESET_CYC    = (RESET_SEQ_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam logic [13:0] INPUT_DEF  = 14'h1555;
  localparam logic [13:0] GAIN_DEF   = 14'h3fff;
  localparam logic [13:0] OFFSET_DEF = 14'h2000;
  localparam logic signed [17:0] CODE_MID = 18'sh02000;
  localparam logic signed [17:0] CODE_MAX = 18'sh03fff;
  localparam int CTRL_PD_BIT   = 0;
  localparam int CTRL_TSD_EN   = 1;
  localparam int CTRL_AB_BIT   = 2;
  localparam int CTRL_TSD_FLAG = 4;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int SEL_BANK_LSB  = 8;
  typedef enum logic [2:0] {WR_INPUT, WR_GAIN, WR_OFFSET, WR_SELECT, WR_CONTROL} mdac_wkind_t;
  typedef enum logic [1:0] {CALC_IDLE, CALC_STAGE, CALC_FINAL} mdac_calc_t;
  typedef struct packed {
    logic              valid;
    mdac_wkind_t       kind;
    logic [CH_NUM-1:0] chans;
    logic [13:0]       data;
  } mdac_wr_t;
  typedef struct packed {
    logic resetPin_n;
    logic outputPark_n;
    logic loadStrobe_n;
    logic busyLine;
    logic overTemp;
  } mdac_pins_t;
  typedef struct packed {
    logic [13:0] inA;
    logic [13:0] inB;
    logic [13:0] gain;
    logic [13:0] offs;
    logic [13:0] resA;
    logic [13:0] resB;
    logic [13:0] dac;
    logic        dirtyA;
    logic        dirtyB;
  } mdac_chan_t;
endpackage : mdac_pkg

// >>> mdac_host_model.sv
// Host-side partner model: control pins, a second device on the busy line and the sensor.
`timescale 1ns/100ps
module mdac_host_model import mdac_pkg::*; (
  // Clock and device status
  input  wire logic       sys_clk,
  input  wire logic       busyOe,
  input  wire logic       resetActive,
  // Pins towards the device
  output wire mdac_pins_t pins
);
  // ****************************************
  // Pin levels and host actions
  // ****************************************
  logic resetN    = 1'h1;
  logic parkN     = 1'h1;
  logic loadN     = 1'h1;
  logic otherPull = 1'h0;
  logic hot       = 1'h0;
  // The busy line has a pull-up, so it reads high unless some device pulls it down.
  assign pins = {resetN, parkN, loadN, !(busyOe || otherPull), hot};

  // Writes stay off until the device reports that its reset sequence has ended.
  task automatic waitReady();
    repeat (4) @(negedge sys_clk);
    for (int i = 0; i < 3200 && resetActive !== 1'h0; i++)
      @(negedge sys_clk);
  endtask : waitReady

  // The pulse lasts two cycles so that the synchronised pin cannot miss it.
  task automatic pulseLoad();
    @(negedge sys_clk) loadN = 1'h0;
    repeat (2) @(negedge sys_clk);
    loadN = 1'h1;
  endtask : pulseLoad
endmodule : mdac_host_model

// >>> tb.sv
// Self-checking testbench of the DAC update control block.
`timescale 1ns/100ps
module tb import mdac_pkg::*; ;
  // ****************************************
  // Harness, tasks and test sequence
  // ****************************************
  typedef struct packed {
    mdac_wkind_t       k;
    logic [CH_NUM-1:0] m;
    logic [13:0]       d;
    logic [5:0]        ch;
    logic [13:0]       e;
  } mdac_row_t;
  logic                          sys_clk = 1'h0;
  logic                          rstn    = 1'h0;
  mdac_wr_t                      wrCmd   = '0;
  mdac_pins_t                    pins;
  logic                          busyOut, busyOe, outputsParked, resetActive;
  logic [CH_NUM-1:0][CODE_W-1:0] chanCode;
  logic [7:0]                    controlRead;
  logic [BANKS-1:0][7:0]         selectRead;
  int                            n_fail = 0, num_checks = 0, n;
  // Gain 0x1fff halves the input code and offset 0x2010 adds 0x10.
  mdac_row_t rows [7] = '{
    '{WR_INPUT,  40'h1,          14'h0123, 6'h00, 14'h0123},
    '{WR_INPUT,  40'hff,         14'h2abc, 6'h07, 14'h2abc},
    '{WR_GAIN,   40'h1,          14'h1fff, 6'h00, 14'h155e},
    '{WR_OFFSET, 40'h1,          14'h2010, 6'h00, 14'h156e},
    '{WR_INPUT,  40'h0101010100, 14'h0777, 6'h08, 14'h0777},
    '{WR_INPUT,  40'h0101010101, 14'h0abc, 6'h20, 14'h0abc},
    '{WR_INPUT,  40'hffffffffff, 14'h3fff, 6'h27, 14'h3fff}
  };
  logic [13:0] selWr  [3] = '{14'h0020, 14'h0480, 14'h0000};
  logic [5:0]  selCh  [3] = '{6'h05, 6'h27, 6'h05};
  logic [13:0] selExp [3] = '{14'h0555, 14'h1555, 14'h3fff};

  mdac_update_ctrl dut_u (
    .sys_clk       (sys_clk),
    .rstn          (rstn),
    .pinIn         (pins),
    .wrCmd         (wrCmd),
    .busyOut       (busyOut),
    .busyOe        (busyOe),
    .chanCode      (chanCode),
    .outputsParked (outputsParked),
    .resetActive   (resetActive),
    .controlRead   (controlRead),
    .selectRead    (selectRead)
  );
  mdac_host_model host_u (
    .sys_clk     (sys_clk),
    .busyOe      (busyOe),
    .resetActive (resetActive),
    .pins        (pins)
  );
  always #50 sys_clk = ~sys_clk;

  task automatic tick(input int k);
    repeat (k) @(negedge sys_clk);
  endtask : tick

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input mdac_wkind_t k, input logic [CH_NUM-1:0] m, input logic [13:0] d);
    @(negedge sys_clk) wrCmd = '{1'h1, k, m, d};
    @(negedge sys_clk) wrCmd.valid = 1'h0;
  endtask : wr

  // Counts the cycles of our own busy drive, sampled between clock edges.
  // The write task returns half a cycle into the busy time, so that first cycle counts too.
  task automatic busyLen(output int len);
    len = (busyOe === 1'h1) ? 1 : 0;
    for (int i = 0; i < 400; i++) begin
      @(negedge sys_clk);
      if (busyOe === 1'h1)
        len++;
      else if (len > 0)
        break;
    end
  endtask : busyLen

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude

  // Roughly three times the expected run, which the reset sequence dominates.
  initial begin
    #1200000;
    n_fail++;
    conclude();
  end

  initial begin
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk) rstn = 1'h1;
    tick(2);
    for (int c = 0; c < CH_NUM; c++)
      chk(chanCode[c], 14'h1555);
    chk(outputsParked, 1'h1);
    chk(controlRead, 8'h00);
    chk(selectRead, 40'h0);
    chk(busyOe, 1'h0);
    foreach (rows[i]) begin
      wr(rows[i].k, rows[i].m, rows[i].d);
      busyLen(n);
      chk(n, ($countones(rows[i].m) + 1) * STAGE_CYC + FINAL_CYC);
      host_u.pulseLoad();
      tick(4);
      chk(chanCode[rows[i].ch], rows[i].e);
    end
    chk(outputsParked, 1'h0);
    host_u.parkN = 1'h0;
    tick(4);
    chk(outputsParked, 1'h1);
    wr(WR_OFFSET, 40'h1, 14'h2020);
    busyLen(n);
    host_u.pulseLoad();
    tick(4);
    chk(chanCode[0], 14'h200f);
    host_u.parkN = 1'h1;
    tick(4);
    chk(outputsParked, 1'h0);
    host_u.pulseLoad();
    tick(4);
    chk(chanCode[0], 14'h201f);
    wr(WR_INPUT, 40'h2, 14'h0100);
    wr(WR_INPUT, 40'h40, 14'h0160);
    host_u.pulseLoad();
    chk(chanCode[1], 14'h3fff);
    busyLen(n);
    tick(4);
    chk(chanCode[1], 14'h0100);
    chk(chanCode[6], 14'h0160);
    host_u.otherPull = 1'h1;
    wr(WR_INPUT, 40'h4, 14'h0200);
    host_u.pulseLoad();
    tick(25);
    chk(chanCode[2], 14'h3fff);
    chk(busyOut, 1'h0);
    host_u.otherPull = 1'h0;
    tick(6);
    chk(chanCode[2], 14'h0200);
    host_u.loadN = 1'h0;
    for (int v = 0; v < 2; v++) begin
      wr(WR_INPUT, 40'h8, 14'h0300 + 14'(v));
      busyLen(n);
      tick(4);
      chk(chanCode[3], 14'h0300 + 14'(v));
    end
    host_u.loadN = 1'h1;
    wr(WR_CONTROL, 40'h0, 14'h0004);
    wr(WR_INPUT, 40'h20, 14'h0555);
    busyLen(n);
    host_u.pulseLoad();
    tick(4);
    chk(chanCode[5], 14'h3fff);
    for (int j = 0; j < 3; j++) begin
      wr(WR_SELECT, 40'h0, selWr[j]);
      busyLen(n);
      chk(n, SEL_CYC);
      host_u.pulseLoad();
      tick(4);
      chk(chanCode[selCh[j]], selExp[j]);
    end
    chk(selectRead, 40'h8000000000);
    wr(WR_CONTROL, 40'h0, 14'h0001);
    tick(3);
    chk(outputsParked, 1'h1);
    chk(controlRead, 8'h01);
    wr(WR_CONTROL, 40'h0, 14'h0002);
    host_u.hot = 1'h1;
    tick(5);
    chk(controlRead, 8'h12);
    chk(outputsParked, 1'h1);
    host_u.hot = 1'h0;
    tick(10);
    chk(controlRead, 8'h12);
    wr(WR_CONTROL, 40'h0, 14'h0000);
    tick(3);
    chk(controlRead, 8'h00);
    chk(outputsParked, 1'h0);
    chk(chanCode[5], 14'h3fff);
    host_u.resetN = 1'h0;
    tick(10);
    chk(resetActive, 1'h0);
    chk(chanCode[0], 14'h201f);
    host_u.resetN = 1'h1;
    tick(5);
    chk(resetActive, 1'h1);
    host_u.waitReady();
    chk(chanCode[0], 14'h1555);
    wr(WR_INPUT, 40'h1, 14'h0077);
    busyLen(n);
    tick(4);
    chk(outputsParked, 1'h1);
    host_u.pulseLoad();
    tick(4);
    chk(outputsParked, 1'h0);
    chk(chanCode[0], 14'h0077);
    conclude();
  end
endmodule : tb
